// ===== bp_debug_pkg.sv
// Constants and types for the hardware breakpoint and debug-exception unit
//
// Contract
// - Four breakpoint address registers, each fully configurable
// - Enabled matching access raises debug exception
// - Type field: execute, write, read-or-write
// - Length field: one, two or four bytes
// - Execute breakpoint fires before instruction retires
// - Register moves allowed only at privilege zero or in real mode
// - Global enable survives task switch
// - Local enable cleared on task switch
// - Access lock bit 13, cleared on exception
// - Hit flags set even for disabled breakpoints
// - Task-switch flag set for trapping task
// - Single-step flag set for trap-flag exceptions
// - Status never cleared automatically by hardware
// - Trap flag raises exception after each instruction
// - Breakpoint instruction acts as code breakpoint
// - Control layout: enables, lock, type, length
// - Status layout: hits, step, task, fixed ones
package bp_debug_pkg;

  localparam int NUM_BP = 4;

  // Register select codes on the move port
  localparam logic [2:0] SEL_ADDR_0  = 3'h0;
  localparam logic [2:0] SEL_ADDR_1  = 3'h1;
  localparam logic [2:0] SEL_ADDR_2  = 3'h2;
  localparam logic [2:0] SEL_ADDR_3  = 3'h3;
  localparam logic [2:0] SEL_STATUS  = 3'h6;
  localparam logic [2:0] SEL_CONTROL = 3'h7;

  // Control register fields
  localparam int CTL_LOCAL_LSB  = 0;
  localparam int CTL_GLOBAL_LSB = 1;
  localparam int CTL_LOCK_BIT   = 13;
  localparam int CTL_TYPE_LSB   = 16;
  localparam int CTL_LEN_LSB    = 18;
  localparam int CTL_FIELD_STEP = 4;
  localparam logic [31:0] CTL_FIXED_ONES = 32'h0000_0400;
  localparam logic [31:0] CTL_RW_MASK    = 32'hFFFF_20FF;

  // Status register fields
  localparam int STS_STEP_BIT = 14;
  localparam int STS_TASK_BIT = 15;
  localparam logic [31:0] STS_FIXED_ONES = 32'h0000_1FF0;

  // Access type and length codes
  localparam logic [1:0] TYPE_EXEC  = 2'h0;
  localparam logic [1:0] TYPE_WRITE = 2'h1;
  localparam logic [1:0] TYPE_RW    = 2'h3;
  localparam logic [1:0] LEN_1      = 2'h0;
  localparam logic [1:0] LEN_2      = 2'h1;
  localparam logic [1:0] LEN_4      = 2'h3;

  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [NUM_BP-1:0][31:0] bp_addr;
    logic [7:0]              enables;
    logic                    lock;
    logic [15:0]             type_len;
    logic [NUM_BP-1:0]       hit_flag;
    logic                    single_step_flag;
    logic                    task_switch_flag;
    logic [31:0]             rd_data;
    logic                    rd_valid;
    logic                    access_fault;
    logic                    debug_exc;
    logic                    code_fault;
  } state_t;

endpackage : bp_debug_pkg

// ===== bp_debug_unit.sv
// Breakpoint compare, debug status and control registers
`timescale 1ns/1ps
module bp_debug_unit (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // Register move port from the core
  input  wire logic        mov_req,
  input  wire logic        mov_write,
  input  wire logic [2:0]  mov_sel,
  input  wire logic [31:0] mov_wdata,
  input  wire logic [1:0]  cpl,
  input  wire logic        real_mode,
  // Instruction fetch, before execution
  input  wire logic        fetch_valid,
  input  wire logic [31:0] fetch_addr,
  input  wire logic        breakpoint_instruction,
  // Instruction retire
  input  wire logic        retire_valid,
  input  wire logic        trap_flag,
  // Data access path
  input  wire logic        data_valid,
  input  wire logic        data_write,
  input  wire logic [31:0] data_addr,
  input  wire logic [2:0]  data_size,
  // Task switch
  input  wire logic        task_switch,
  input  wire logic        task_trap_bit,
  // Outputs
  output logic [31:0]      mov_rdata,
  output logic             mov_rvalid,
  output logic             mov_fault,
  output logic             debug_exc,
  output logic             code_fault
);
  import bp_debug_pkg::*;

  state_t r;
  state_t next_r;

  logic [NUM_BP-1:0] code_match;
  logic [NUM_BP-1:0] data_match;
  logic [NUM_BP-1:0] any_match;
  logic [NUM_BP-1:0] bp_enabled;
  logic [31:0]       ctl_view;
  logic [31:0]       sts_view;
  logic              priv_ok;
  logic              mov_ok;

  // Mask that aligns an address to the watched length
  function automatic logic [31:0] len_mask(input logic [1:0] len);
    logic [31:0] m;
    m = 32'hFFFF_FFFF;
    unique case (len)
      LEN_2:   m = 32'hFFFF_FFFE;
      LEN_4:   m = 32'hFFFF_FFFC;
      default: m = 32'hFFFF_FFFF;
    endcase
    return m;
  endfunction : len_mask

  // Overlap test between an access and the aligned watch window
  function automatic logic overlap(input logic [31:0] bp,
                                   input logic [1:0]  len,
                                   input logic [31:0] a,
                                   input logic [2:0]  sz);
    logic [31:0] lo;
    logic [31:0] hi;
    logic [31:0] alo;
    logic [31:0] ahi;
    lo  = bp & len_mask(len);
    hi  = lo | ~len_mask(len);
    alo = a;
    ahi = a + {29'h0, sz} - 32'h0000_0001;
    return (alo <= hi) && (ahi >= lo);
  endfunction : overlap

  always_comb begin
    ctl_view = CTL_FIXED_ONES;
    ctl_view[7:0] = r.enables;
    ctl_view[CTL_LOCK_BIT] = r.lock;
    ctl_view[31:16] = r.type_len;
    sts_view = STS_FIXED_ONES;
    sts_view[NUM_BP-1:0] = r.hit_flag;
    sts_view[STS_STEP_BIT] = r.single_step_flag;
    sts_view[STS_TASK_BIT] = r.task_switch_flag;
  end

  // Per-breakpoint compare, independent of enables
  always_comb begin
    for (int n = 0; n < NUM_BP; n++) begin
      logic [1:0] typ;
      logic [1:0] len;
      typ = r.type_len[CTL_FIELD_STEP*n +: 2];
      len = r.type_len[CTL_FIELD_STEP*n + 2 +: 2];
      // Execute match uses the whole address; length is ignored
      code_match[n] = fetch_valid && (typ == TYPE_EXEC) &&
                      (fetch_addr == r.bp_addr[n]);
      data_match[n] = data_valid && (data_size != 3'h0) &&
                      ((typ == TYPE_RW) ||
                       (typ == TYPE_WRITE && data_write)) &&
                      overlap(r.bp_addr[n], len,
                              data_addr, data_size);
      any_match[n]  = code_match[n] || data_match[n];
      bp_enabled[n] = r.enables[CTL_LOCAL_LSB + 2*n] ||
                      r.enables[CTL_GLOBAL_LSB + 2*n];
    end
  end

  assign priv_ok = real_mode || (cpl == 2'h0);
  // The lock refuses every move while set
  assign mov_ok  = mov_req && priv_ok && !r.lock;

  always_comb begin
    logic bp_fire;
    logic step_fire;
    logic task_fire;
    logic exc;
    bp_fire   = |(any_match & bp_enabled);
    step_fire = retire_valid && trap_flag;
    task_fire = task_switch && task_trap_bit;
    exc       = bp_fire || step_fire || task_fire ||
                (fetch_valid && breakpoint_instruction);

    next_r = r;
    next_r.rd_valid     = 1'b0;
    next_r.access_fault = mov_req && !mov_ok;
    next_r.debug_exc    = exc;
    // Fault form: the fetched instruction must not retire
    next_r.code_fault   = |(code_match & bp_enabled) ||
                          (fetch_valid && breakpoint_instruction);

    // Software moves first, so hardware events below win
    if (mov_ok && mov_write) begin
      unique case (mov_sel)
        SEL_ADDR_0, SEL_ADDR_1, SEL_ADDR_2, SEL_ADDR_3:
          next_r.bp_addr[mov_sel[1:0]] = mov_wdata;
        SEL_CONTROL: begin
          next_r.enables  = mov_wdata[7:0];
          next_r.lock     = mov_wdata[CTL_LOCK_BIT];
          next_r.type_len = mov_wdata[31:16];
        end
        SEL_STATUS: begin
          // Only software clears the status bits
          next_r.hit_flag         = mov_wdata[NUM_BP-1:0];
          next_r.single_step_flag = mov_wdata[STS_STEP_BIT];
          next_r.task_switch_flag = mov_wdata[STS_TASK_BIT];
        end
        default: ;
      endcase
    end
    if (mov_ok && !mov_write) begin
      next_r.rd_valid = 1'b1;
      unique case (mov_sel)
        SEL_ADDR_0, SEL_ADDR_1, SEL_ADDR_2, SEL_ADDR_3:
          next_r.rd_data = r.bp_addr[mov_sel[1:0]];
        SEL_CONTROL: next_r.rd_data = ctl_view;
        SEL_STATUS:  next_r.rd_data = sts_view;
        default:     next_r.rd_data = RESET_ZERO;
      endcase
    end

    if (task_switch) begin
      for (int n = 0; n < NUM_BP; n++)
        next_r.enables[CTL_LOCAL_LSB + 2*n] = 1'b0;
    end
    if (exc) begin
      next_r.lock = 1'b0;
      // Hits are recorded for all matches, enabled or not
      next_r.hit_flag = next_r.hit_flag | any_match;
      if (step_fire)
        next_r.single_step_flag = 1'b1;
      if (task_fire)
        next_r.task_switch_flag = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign mov_rdata  = r.rd_data;
  assign mov_rvalid = r.rd_valid;
  assign mov_fault  = r.access_fault;
  assign debug_exc  = r.debug_exc;
  assign code_fault = r.code_fault;

endmodule : bp_debug_unit

// ===== bp_debug_unit_asserts.sv
// Port assertions for the breakpoint unit
`timescale 1ns/1ps
module bp_debug_unit_asserts (
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        ce,
  // Core requests
  input wire logic        mov_req,
  input wire logic [2:0]  mov_sel,
  input wire logic [1:0]  cpl,
  input wire logic        real_mode,
  input wire logic        fetch_valid,
  input wire logic        breakpoint_instruction,
  input wire logic        retire_valid,
  input wire logic        trap_flag,
  input wire logic        data_valid,
  input wire logic        task_switch,
  // Answers
  input wire logic [31:0] mov_rdata,
  input wire logic        mov_rvalid,
  input wire logic        mov_fault,
  input wire logic        debug_exc,
  input wire logic        code_fault
);
  import bp_debug_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_PRIV: assert property (
    mov_req && ce && cpl != 2'h0 && !real_mode |=> mov_fault)
    else $error("move not refused");
  AST_FAULT: assert property (
    mov_fault |-> $past(mov_req) && !mov_rvalid)
    else $error("stray refusal");
  AST_STEP: assert property (
    retire_valid && trap_flag && ce |=> debug_exc)
    else $error("no step exception");
  AST_BREAKPOINT_INSTRUCTION: assert property (
    fetch_valid && breakpoint_instruction && ce |=> debug_exc)
    else $error("no breakpoint opcode exception");
  AST_CODE: assert property (
    code_fault |-> debug_exc && $past(fetch_valid))
    else $error("bad code fault");
  AST_CAUSE: assert property (
    debug_exc |->
      $past(fetch_valid || data_valid || retire_valid || task_switch))
    else $error("exception without cause");
  AST_STS: assert property (
    mov_rvalid && $past(mov_sel) == SEL_STATUS |->
      mov_rdata[12:4] == 9'h1ff && mov_rdata[31:16] == 16'h0000)
    else $error("status fixed bits");
  AST_CTL: assert property (
    mov_rvalid && $past(mov_sel) == SEL_CONTROL |->
      mov_rdata[10] && mov_rdata[15:14] == 2'h0)
    else $error("control fixed bits");
endmodule : bp_debug_unit_asserts

bind bp_debug_unit bp_debug_unit_asserts u_asserts (.*);

// ===== core_model.sv
// Core model issuing fetch, data, retire and task events
`timescale 1ns/1ps
module core_model (
  // Clock
  input  wire logic   clk,
  // Events
  output logic        fetch_valid,
  output logic [31:0] fetch_addr,
  output logic        breakpoint_instruction,
  output logic        retire_valid,
  output logic        trap_flag,
  output logic        data_valid,
  output logic        data_write,
  output logic [31:0] data_addr,
  output logic [2:0]  data_size,
  output logic        task_switch,
  output logic        task_trap_bit
);
  // Released lines show the inverse so a stale value cannot match
  task automatic ev(input int k, input logic [31:0] a,
                    input logic [2:0] s);
    @(negedge clk);
    {fetch_valid, breakpoint_instruction} = {k < 2, k == 1};
    {data_valid, data_write} = {k inside {2, 3}, k == 2};
    {retire_valid, trap_flag} = {2{k == 4}};
    {task_switch, task_trap_bit} = {2{k == 5}};
    {fetch_addr, data_addr, data_size} = {a, a, s};
    @(negedge clk);
    {fetch_valid, data_valid, retire_valid, task_switch} = 4'h0;
    {fetch_addr, data_addr, data_size} = ~{a, a, s};
  endtask : ev
  initial {fetch_valid, breakpoint_instruction, retire_valid, trap_flag,
    data_valid, data_write, task_switch, task_trap_bit, fetch_addr,
    data_addr, data_size} = 75'h0;
endmodule : core_model

// ===== testbench.sv
// Self-checking bench for the breakpoint unit
`timescale 1ns/1ps
module testbench;
  import bp_debug_pkg::*;
  logic        clk = 0, resetn = 0, ce = 1, mov_req = 0, mov_write = 0;
  logic        real_mode = 0, mov_rvalid, mov_fault, debug_exc, code_fault;
  logic        fetch_valid, breakpoint_instruction, retire_valid, trap_flag;
  logic        data_valid, data_write, task_switch, task_trap_bit;
  logic [1:0]  cpl = 0;
  logic [2:0]  mov_sel = 0, data_size;
  logic [31:0] mov_wdata = 0, mov_rdata, fetch_addr, data_addr, v;
  logic [31:0] m_ctl = CTL_FIXED_ONES, m_sts = STS_FIXED_ONES, m_adr [4];
  logic [1:0]  cd [3] = '{TYPE_EXEC, TYPE_WRITE, TYPE_RW};
  int          fails = 0, checks = 0, seed = 32'h3b20_d20f;
  bp_debug_unit i_dut (.*);
  core_model    i_core (.*);
  initial forever #25 clk = ~clk;
  initial begin
    #100us;
    fails++;
    wrap_up;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Exec match ignores length; data ranges are aligned to their length
  function automatic logic hit(int n, int k, logic [31:0] a,
                               logic [2:0] s);
    logic [1:0] t;
    longint     b, w;
    t = m_ctl[CTL_TYPE_LSB + 4 * n +: 2];
    w = m_ctl[CTL_LEN_LSB + 4 * n +: 2] == LEN_4 ? 4 :
        m_ctl[CTL_LEN_LSB + 4 * n +: 2] == LEN_2 ? 2 : 1;
    b = m_adr[n] & ~(w - 1);
    if (k < 2) return t == TYPE_EXEC && a == m_adr[n];
    if (k > 3 || s == 0) return 0;
    return (t == TYPE_RW || t == TYPE_WRITE && k == 2) && a < b + w &&
           a + s > b;
  endfunction : hit
  task automatic mv(input logic w, input logic [2:0] s,
                    input logic [31:0] d);
    logic ok;
    ok = (real_mode || cpl == 0) && !m_ctl[CTL_LOCK_BIT];
    @(negedge clk);
    {mov_req, mov_write, mov_sel, mov_wdata} = {1'b1, w, s, d};
    @(negedge clk);
    {mov_req, mov_wdata} = {1'b0, ~d};
    chk({mov_rvalid, mov_fault}, {ok && !w, !ok});
    if (ok && !w) chk(mov_rdata, s < 4 ? m_adr[s[1:0]] :
      s == SEL_STATUS ? m_sts : m_ctl);
    if (ok && w && s < 4) m_adr[s[1:0]] = d;
    if (ok && w && s == SEL_STATUS) m_sts = d & 32'h0000_c00f | STS_FIXED_ONES;
    if (ok && w && s == SEL_CONTROL) m_ctl = d & CTL_RW_MASK | 32'h0000_0400;
  endtask : mv
  task automatic ex(input int k, input logic [31:0] a, input logic [2:0] s);
    logic [3:0] h;
    logic       e, f;
    {e, f} = {k == 1 || k == 4 || k == 5, k == 1};
    for (int n = 0; n < 4; n++) begin
      h[n] = hit(n, k, a, s);
      if (h[n] && (m_ctl[2 * n] || m_ctl[2 * n + 1])) {e, f} = {1'b1, k < 2};
    end
    i_core.ev(k, a, s);
    chk({debug_exc, code_fault}, {e, f});
    if (e) m_sts[3:0] = m_sts[3:0] | h;
    if (e) m_ctl[CTL_LOCK_BIT] = 0;
    if (k == 4) m_sts[STS_STEP_BIT] = 1;
    if (k == 5) m_sts[STS_TASK_BIT] = 1;
    if (k == 5) m_ctl = m_ctl & ~32'h0000_0055;
  endtask : ex
  task automatic wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  initial begin
    m_adr = '{default: 0};
    repeat (16) @(negedge clk);
    resetn = 1;
    mv(0, SEL_CONTROL, 0);
    mv(0, SEL_STATUS, 0);
    cpl = 2'h3;
    mv(0, SEL_ADDR_0, 0);
    real_mode = 1;
    mv(0, SEL_ADDR_0, 0);
    {cpl, real_mode} = 3'h0;
    for (int i = 0; i < 9; i++) begin
      v = $random(seed) & 32'h7fff_fff0 | i;
      mv(1, SEL_ADDR_0, v);
      mv(1, SEL_ADDR_1, v);
      // Slot 1 mirrors slot 0 but stays disabled
      mv(1, SEL_CONTROL, {8'h00, {2{cd[i % 3], cd[i / 3]}}, 16'h0401});
      ex(0, v, 0);
      for (int j = 0; j < 6; j++)
        ex(2 + j % 2, v - 3 + ($random(seed) & 7), 3'(1 << j % 3));
      mv(0, SEL_STATUS, 0);
      mv(1, SEL_STATUS, 0);
      $display("case %0d done", i);
    end
    mv(1, SEL_CONTROL, 32'h0000_2400);
    mv(0, SEL_ADDR_0, 0);
    ex(4, 0, 0);
    ex(1, 0, 0);
    mv(0, SEL_STATUS, 0);
    mv(1, SEL_CONTROL, 32'h0000_0406);
    ex(5, 0, 0);
    mv(0, SEL_CONTROL, 0);
    mv(0, SEL_STATUS, 0);
    $display("lock, step and task done");
    wrap_up;
  end
endmodule : testbench
